// [rtl/dcp_pkg.sv]
// ****************************************************************
// Shared constants of the peripheral control block
// ****************************************************************
package dcp_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_FREQ_MHZ     = 10;     // System clock rate
    localparam int STEP_TIME_US     = 100;    // Length of one display step
    localparam int STEP_CYC         = STEP_TIME_US * CLK_FREQ_MHZ;
    localparam int DISCH_TIME_US    = 20;     // Ramp discharge time
    localparam int DISCH_CYC        = DISCH_TIME_US * CLK_FREQ_MHZ;
    localparam int CHARGE_UNIT_CYC  = 4;      // Charge cycles per ramp code
    localparam int SPI_RISE_CNT     = 3;      // Divider count of serial clock rise
    localparam int SPI_FALL_CNT     = 7;      // Divider count of fall and sample
    localparam int TMR_W            = 12;     // Width of shared timers

    // ************************************************************
    // Protocol values
    // ************************************************************
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h1B;  // Control port address
    localparam logic [7:0] FLASH_READ_CMD  = 8'h03;  // Plain flash read
    localparam logic [2:0] BOOT_HDR_LAST   = 3'h3;   // Command plus 3 address bytes
    localparam logic [2:0] BOOT_LAST       = 3'h7;   // Last boot byte index
    localparam int         SEQ_STEPS       = 4;      // Codes in display sequence

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [1:0] LSEL_RST   = 2'h0;  // Light sources off
    localparam logic [7:0] CMD_RST    = 8'h00; // No command pending
    localparam logic [7:0] TEMP_RST   = 8'h00; // No conversion yet

    // ************************************************************
    // State encodings
    // ************************************************************
    typedef enum logic [2:0] {
        BOOT_START = 3'b001,
        BOOT_XFER  = 3'b010,
        BOOT_RUN   = 3'b100
    } dcp_boot_e;

    typedef enum logic [4:0] {
        I2C_IDLE  = 5'b00001,
        I2C_ADDR  = 5'b00010,
        I2C_WRITE = 5'b00100,
        I2C_ACK   = 5'b01000,
        I2C_READ  = 5'b10000
    } dcp_i2c_e;

    typedef enum logic [2:0] {
        SAR_IDLE   = 3'b001,
        SAR_CHARGE = 3'b010,
        SAR_DISCH  = 3'b100
    } dcp_sar_e;

endpackage

// [rtl/dcp_spi_byte.sv]
`timescale 1ns/10ps
// ****************************************************************
// Serial master byte shifter, clock divided by eight
// ****************************************************************
module dcp_spi_byte
    import dcp_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Byte request
    input  wire logic       go,
    input  wire logic [7:0] tx,
    output logic            busy_q,
    output logic            done_q,
    output logic [7:0]      rx_q,
    // Serial lines
    input  wire logic       miso_sync,
    output logic            sclk_q,
    output logic            mosi_q
);
    logic [2:0] div_q;   // Divider phase
    logic [2:0] bit_q;   // Bit within byte
    logic [7:0] sh_q;    // Outgoing shift register

    wire rise_pt = busy_q && (div_q == 3'(SPI_RISE_CNT));
    wire fall_pt = busy_q && (div_q == 3'(SPI_FALL_CNT));

    // Mode 0: data set while clock low, flash and we both sample on the high phase.
    // Sampling late in the high phase hides the two-stage input synchroniser delay.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rx_q   <= 8'h00;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            div_q  <= 3'h0;
            bit_q  <= 3'h0;
            sh_q   <= 8'h00;
        end else begin
            done_q <= 1'b0;
            if (go && !busy_q) begin
                busy_q <= 1'b1;
                sh_q   <= tx;
                mosi_q <= tx[7];
                div_q  <= 3'h0;
                bit_q  <= 3'h0;
            end else if (busy_q) begin
                div_q <= div_q + 3'h1;
                if (rise_pt) begin
                    sclk_q <= 1'b1;
                end
                if (fall_pt) begin
                    sclk_q <= 1'b0;
                    rx_q   <= {rx_q[6:0], miso_sync};
                    sh_q   <= {sh_q[6:0], 1'b0};
                    mosi_q <= sh_q[6];
                    bit_q  <= bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// [rtl/dcp_periph_io.sv]
`timescale 1ns/10ps
// Operation
// - Host interrupt released while reset held
// - Interrupt high during init, low when done
// - Light selects low during reset
// - Light selects low until init completes
// - Sequence drives light selects, not host
// - Serial master, select 0 flash, select 1 idle
// - Generate clock, shift out, sample in
// - Host commands arrive over I2C target port
// - I2C lines only pulled low, inputs synchronised
// - Successive approximation via ramp and comparator
// - Ramp output feeds external Ramp_charge_out circuit
module dcp_periph_io
    import dcp_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Host interrupt, three-state
    output logic            host_irq_out,
    output logic            host_irq_oe,
    // Light source selection
    output logic [1:0]      light_source_select,
    // Flash serial port
    output logic            flash_serial_clock,
    output logic            flash_select_n,
    output logic            spare_select_n,
    output logic            flash_serial_out,
    input  wire logic       flash_serial_in,
    // Control bus, open drain
    input  wire logic       control_bus_clock_in,
    output logic            control_bus_clock_out,
    output logic            control_bus_clock_oe,
    input  wire logic       control_bus_data_in,
    output logic            control_bus_data_out,
    output logic            control_bus_data_oe,
    // Thermistor interface
    input  wire logic       comparator_result_in,
    output logic            ramp_charge_out
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] miso_s_q;           // Flash data in
    logic [2:0] scl_s_q;            // Bus clock, third stage for edges
    logic [2:0] sda_s_q;            // Bus data, third stage for edges
    logic [1:0] cmp_s_q;            // Comparator result

    // Pins are asynchronous; two stages before any logic looks at them
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            miso_s_q <= 2'h0;
            scl_s_q  <= 3'h7;
            sda_s_q  <= 3'h7;
            cmp_s_q  <= 2'h0;
        end else begin
            miso_s_q <= {miso_s_q[0], flash_serial_in};
            scl_s_q  <= {scl_s_q[1:0], control_bus_clock_in};
            sda_s_q  <= {sda_s_q[1:0], control_bus_data_in};
            cmp_s_q  <= {cmp_s_q[0], comparator_result_in};
        end
    end

    wire scl    = scl_s_q[1];
    wire sda    = sda_s_q[1];
    wire scl_up = scl_s_q[1] && !scl_s_q[2];
    wire scl_dn = !scl_s_q[1] && scl_s_q[2];
    wire i2c_st = scl && scl_s_q[2] && !sda_s_q[1] && sda_s_q[2];
    wire i2c_sp = scl && scl_s_q[2] && sda_s_q[1] && !sda_s_q[2];

    // ************************************************************
    // Boot read from flash
    // ************************************************************
    dcp_boot_e  boot_q;             // Initialisation state
    logic [2:0] bidx_q;             // Boot byte index
    logic       spi_go_q;           // Byte request pulse
    logic [7:0] spi_tx_q;           // Byte to send
    logic [1:0] seq_q [SEQ_STEPS];  // Display sequence codes
    logic       spi_busy;
    logic       spi_done;
    logic [7:0] spi_rx;
    logic       init_done_q;        // Initialisation finished

    dcp_spi_byte u_spi (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .go        (spi_go_q),
        .tx        (spi_tx_q),
        .busy_q    (spi_busy),
        .done_q    (spi_done),
        .rx_q      (spi_rx),
        .miso_sync (miso_s_q[1]),
        .sclk_q    (flash_serial_clock),
        .mosi_q    (flash_serial_out)
    );

    wire [7:0] boot_tx = (bidx_q == 3'h0) ? FLASH_READ_CMD : 8'h00;

    // Read command, zero address, then one byte per sequence step
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            boot_q         <= BOOT_START;
            bidx_q         <= 3'h0;
            spi_go_q       <= 1'b0;
            spi_tx_q       <= 8'h00;
            flash_select_n <= 1'b1;
            spare_select_n <= 1'b1;
            init_done_q    <= 1'b0;
            for (int i = 0; i < SEQ_STEPS; i++) begin
                seq_q[i] <= LSEL_RST;
            end
        end else begin
            spi_go_q <= 1'b0;
            case (boot_q)
                BOOT_START: begin
                    flash_select_n <= 1'b0;
                    spi_tx_q       <= boot_tx;
                    spi_go_q       <= 1'b1;
                    boot_q         <= BOOT_XFER;
                end
                BOOT_XFER: begin
                    if (spi_done) begin
                        if (bidx_q > BOOT_HDR_LAST) begin
                            seq_q[bidx_q[1:0]] <= spi_rx[1:0];
                        end
                        if (bidx_q == BOOT_LAST) begin
                            flash_select_n <= 1'b1;
                            init_done_q    <= 1'b1;
                            boot_q         <= BOOT_RUN;
                        end else begin
                            bidx_q <= bidx_q + 3'h1;
                            boot_q <= BOOT_START;
                        end
                    end
                end
                BOOT_RUN: begin
                    boot_q <= BOOT_RUN;
                end
                default: begin
                    boot_q <= BOOT_START;
                end
            endcase
        end
    end

    // ************************************************************
    // Host interrupt
    // ************************************************************
    // Floating in reset; the external pullup shows high until we drive.
    // The host relies on the low edge before releasing the park request.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            host_irq_oe  <= 1'b0;
            host_irq_out <= 1'b1;
        end else begin
            host_irq_oe  <= 1'b1;
            host_irq_out <= !init_done_q;
        end
    end

    // ************************************************************
    // Control bus target
    // ************************************************************
    dcp_i2c_e   i2c_q;              // Bus state
    logic [3:0] bcnt_q;             // Clock rises in current byte
    logic [7:0] rsh_q;              // Receive shift
    logic [7:0] tsh_q;              // Transmit shift
    logic       rw_q;               // Read transfer
    logic       rsel_q;             // Next read byte: 0 status, 1 temperature
    logic [7:0] cmd_q;              // Last command byte
    logic [7:0] temp_q;             // Conversion result
    logic       sar_busy;

    wire addr_hit = (rsh_q[7:1] == I2C_TARGET_ADDR);
    wire [7:0] rd_byte = rsel_q ? temp_q
                                : {init_done_q, sar_busy, 5'h00, cmd_q[0]};

    // Bits are taken on clock rise; our data line only changes on clock fall
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            i2c_q                 <= I2C_IDLE;
            bcnt_q                <= 4'h0;
            rsh_q                 <= 8'h00;
            tsh_q                 <= 8'h00;
            rw_q                  <= 1'b0;
            rsel_q                <= 1'b0;
            cmd_q                 <= CMD_RST;
            control_bus_data_oe   <= 1'b0;
            control_bus_data_out  <= 1'b0;
            control_bus_clock_oe  <= 1'b0;
            control_bus_clock_out <= 1'b0;
        end else begin
            control_bus_data_out  <= 1'b0;
            control_bus_clock_out <= 1'b0;
            control_bus_clock_oe  <= 1'b0;                           // No stretching
            cmd_q[1]              <= 1'b0;                           // Start is a pulse
            if (i2c_sp) begin
                i2c_q               <= I2C_IDLE;
                control_bus_data_oe <= 1'b0;
            end else if (i2c_st) begin
                i2c_q               <= I2C_ADDR;
                bcnt_q              <= 4'h0;
                rsel_q              <= 1'b0;
                control_bus_data_oe <= 1'b0;
            end else if (scl_up && (i2c_q != I2C_IDLE)) begin
                bcnt_q <= bcnt_q + 4'h1;
                rsh_q  <= {rsh_q[6:0], sda};
            end else if (scl_dn) begin
                case (i2c_q)
                    I2C_ADDR: begin
                        if (bcnt_q == 4'h8) begin
                            if (addr_hit) begin
                                rw_q                <= rsh_q[0];
                                control_bus_data_oe <= 1'b1;        // Acknowledge
                                i2c_q               <= I2C_ACK;
                            end else begin
                                i2c_q <= I2C_IDLE;
                            end
                        end
                    end
                    I2C_WRITE: begin
                        if (bcnt_q == 4'h8) begin
                            cmd_q               <= rsh_q;
                            control_bus_data_oe <= 1'b1;
                            i2c_q               <= I2C_ACK;
                        end
                    end
                    I2C_ACK: begin
                        bcnt_q <= 4'h0;
                        if (rw_q) begin
                            tsh_q               <= {rd_byte[6:0], 1'b0};
                            control_bus_data_oe <= !rd_byte[7];
                            rsel_q              <= !rsel_q;
                            i2c_q               <= I2C_READ;
                        end else begin
                            control_bus_data_oe <= 1'b0;
                            i2c_q               <= I2C_WRITE;
                        end
                    end
                    I2C_READ: begin
                        if (bcnt_q < 4'h8) begin
                            control_bus_data_oe <= !tsh_q[7];
                            tsh_q               <= {tsh_q[6:0], 1'b0};
                        end else if (bcnt_q == 4'h8) begin
                            control_bus_data_oe <= 1'b0;            // Host acknowledges
                        end else if (rsh_q[0]) begin
                            i2c_q <= I2C_IDLE;                      // Host said no more
                        end else begin
                            bcnt_q              <= 4'h0;
                            tsh_q               <= {rd_byte[6:0], 1'b0};
                            control_bus_data_oe <= !rd_byte[7];
                            rsel_q              <= !rsel_q;
                        end
                    end
                    I2C_IDLE: begin
                        control_bus_data_oe <= 1'b0;
                    end
                    default: begin
                        i2c_q <= I2C_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Display sequence
    // ************************************************************
    logic [9:0] step_tmr_q;         // Cycles into current step
    logic [1:0] step_q;             // Current step
    wire        step_end = (step_tmr_q == 10'(STEP_CYC - 1));

    // Command bit 0 runs the sequence; the host never picks a code itself.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            step_tmr_q          <= 10'h000;
            step_q              <= 2'h0;
            light_source_select <= LSEL_RST;
        end else if (!init_done_q || !cmd_q[0]) begin
            step_tmr_q          <= 10'h000;
            step_q              <= 2'h0;
            light_source_select <= LSEL_RST;
        end else begin
            step_tmr_q <= step_end ? 10'h000 : step_tmr_q + 10'h001;
            if (step_end || (step_tmr_q == 10'h000)) begin
                light_source_select <= seq_q[step_q];
            end
            if (step_end) begin
                step_q <= step_q + 2'h1;
            end
        end
    end

    // ************************************************************
    // Thermistor conversion
    // ************************************************************
    dcp_sar_e          sar_q;       // Conversion state
    logic [TMR_W-1:0]  sar_tmr_q;   // Charge or discharge time left
    logic [7:0]        trial_q;     // Code under test
    logic [7:0]        bitm_q;      // Bit being decided

    assign sar_busy = (sar_q != SAR_IDLE);
    wire [TMR_W-1:0] charge_len = TMR_W'(trial_q) * TMR_W'(CHARGE_UNIT_CYC);

    // Ramp high for a time set by the trial code, then compare.
    // A high comparator means the ramp passed the thermistor: clear the bit.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sar_q           <= SAR_IDLE;
            sar_tmr_q       <= '0;
            trial_q         <= 8'h00;
            bitm_q          <= 8'h00;
            temp_q          <= TEMP_RST;
            ramp_charge_out <= 1'b0;
        end else begin
            case (sar_q)
                SAR_IDLE: begin
                    ramp_charge_out <= 1'b0;
                    if (cmd_q[1]) begin
                        trial_q   <= 8'h80;
                        bitm_q    <= 8'h80;
                        sar_tmr_q <= TMR_W'(DISCH_CYC);
                        sar_q     <= SAR_DISCH;
                    end
                end
                SAR_DISCH: begin
                    ramp_charge_out <= 1'b0;
                    if (sar_tmr_q != '0) begin
                        sar_tmr_q <= sar_tmr_q - 1'b1;
                    end else if (bitm_q == 8'h00) begin
                        temp_q <= trial_q;
                        sar_q  <= SAR_IDLE;
                    end else begin
                        sar_tmr_q       <= charge_len;
                        ramp_charge_out <= 1'b1;
                        sar_q           <= SAR_CHARGE;
                    end
                end
                SAR_CHARGE: begin
                    if (sar_tmr_q != '0) begin
                        sar_tmr_q <= sar_tmr_q - 1'b1;
                    end else begin
                        ramp_charge_out <= 1'b0;
                        trial_q <= (cmp_s_q[1] ? (trial_q & ~bitm_q) : trial_q)
                                   | (bitm_q >> 1);
                        bitm_q    <= bitm_q >> 1;
                        sar_tmr_q <= TMR_W'(DISCH_CYC);
                        sar_q     <= SAR_DISCH;
                    end
                end
                default: begin
                    sar_q <= SAR_IDLE;
                end
            endcase
        end
    end
endmodule

// [verif/dcp_periph_io_checker.sv]
`timescale 1ns/10ps
// ****************************************************************
// Port checker, watches only the block's pins
// ****************************************************************
module dcp_periph_io_checker (
    // Clock, reset, interrupt, light select, flash, control bus
    input wire logic       mclk, rst_b, host_irq_out, host_irq_oe,
    input wire logic [1:0] light_source_select,
    input wire logic       flash_serial_clock, flash_select_n, spare_select_n, flash_serial_out,
    input wire logic       control_bus_clock_oe, control_bus_data_out, control_bus_data_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_irq_held: assert property (host_irq_oe |=> host_irq_oe)
        else $error("interrupt released after init start");
    chk_irq_done: assert property ($rose(flash_select_n) |=> $fell(host_irq_out))
        else $error("interrupt did not drop after boot");
    chk_lsel_init: assert property (host_irq_out |-> light_source_select == 2'h0)
        else $error("light select on during init");
    chk_lsel_step: assert property ($changed(light_source_select) |=>
        $stable(light_source_select)[*8]) else $error("light select glitch");
    chk_spare_idle: assert property (spare_select_n) else $error("spare select used");
    chk_sclk_sel: assert property (flash_serial_clock |-> !flash_select_n)
        else $error("serial clock without select");
    chk_sclk_high: assert property ($rose(flash_serial_clock) |->
        flash_serial_clock[*4] ##1 !flash_serial_clock) else $error("serial clock width");
    chk_mosi_hold: assert property (flash_serial_clock |-> $stable(flash_serial_out))
        else $error("serial data moved while clock high");
    chk_bus_pull: assert property (!control_bus_clock_oe &&
        !(control_bus_data_oe && control_bus_data_out)) else $error("control bus driven high");
    cover property ($fell(host_irq_out));
    cover property ($changed(light_source_select) && light_source_select != 2'h0);
    cover property ($rose(control_bus_data_oe));
endmodule
bind dcp_periph_io dcp_periph_io_checker u_chk (.mclk, .rst_b, .host_irq_out, .host_irq_oe,
    .light_source_select, .flash_serial_clock, .flash_select_n, .spare_select_n,
    .flash_serial_out, .control_bus_clock_oe, .control_bus_data_out, .control_bus_data_oe);

// [verif/dcp_flash_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// Boot flash, mode 0, shifts on the falling serial clock
// ****************************************************************
module dcp_flash_model (
    input wire logic  mclk, sclk, sel_n, mosi,
    output logic      miso,
    output logic [31:0] hdr
);
    // Header bytes ignored, then four display codes 1,2,3,2
    localparam logic [63:0] IMG = 64'h0000_0000_0102_0302;
    logic sclk_d = 1'b0;
    int   nf = 0, nr = 0;
    // Deselected line shows the inverse of the last bit, not a stale copy
    assign miso = sel_n ? ~IMG[0] : IMG[6'(63 - nf)];
    // Edge tracking; capture the first 32 bits sent as the header
    always @(posedge mclk) begin
        sclk_d <= sclk;
        if (sel_n) begin
            nf <= 0;
            nr <= 0;
        end else begin
            if (sclk && !sclk_d && nr < 32) hdr <= {hdr[30:0], mosi};
            if (sclk && !sclk_d) nr <= nr + 1;
            if (!sclk && sclk_d) nf <= nf + 1;
        end
    end
endmodule

// [verif/dcp_periph_io_tb_top.sv]
`timescale 1ns/10ps
module dcp_periph_io_tb_top;
    import dcp_pkg::*;
    logic mclk = 0, rst_b = 0, scl = 1, sda_lo = 0, cmp = 0;
    logic irq_out, irq_oe, fsclk, fsel_n, spare_n, fmosi, fmiso, sclo, scloe, sdao, sdaoe, ramp;
    logic [1:0]  lsel;
    logic [31:0] hdr;
    logic [1:0]  ack;
    logic [7:0]  st, tp;
    int bad_count = 0, n_checks = 0, cyc = 0;
    wire sda = !(sda_lo || sdaoe); // Pulled-up open-drain wire
    always #50 mclk = ~mclk;
    dcp_periph_io u_dut (.mclk(mclk), .rst_b(rst_b), .host_irq_out(irq_out),
        .host_irq_oe(irq_oe), .light_source_select(lsel), .flash_serial_clock(fsclk),
        .flash_select_n(fsel_n), .spare_select_n(spare_n), .flash_serial_out(fmosi),
        .flash_serial_in(fmiso), .control_bus_clock_in(scl), .control_bus_clock_out(sclo),
        .control_bus_clock_oe(scloe), .control_bus_data_in(sda), .control_bus_data_out(sdao),
        .control_bus_data_oe(sdaoe), .comparator_result_in(cmp), .ramp_charge_out(ramp));
    dcp_flash_model u_flash (.mclk(mclk), .sclk(fsclk), .sel_n(fsel_n), .mosi(fmosi),
        .miso(fmiso), .hdr(hdr));
    // Thermistor side: comparator goes high once the ramp has charged past code 5A
    // Trip sits mid-code so a cycle of sync skew cannot change the decided bit
    localparam int TRIP = CHARGE_UNIT_CYC * 'h5A + 1;
    int chg = 0;
    always @(negedge mclk) begin
        chg = ramp ? chg + 1 : 0;
        cmp = (chg > TRIP);
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard, well beyond the longest expected run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            stop_test;
        end
    end
    // ****************************************************************
    // Control bus host, SCL high for 10 mclk, low for 20 mclk
    // ****************************************************************
    task hw; repeat (10) @(negedge mclk); endtask
    task automatic xfer(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_lo = !b[i]; hw; scl = 1; hw; r[i] = sda; scl = 0; hw;
        end
    endtask
    task automatic i2c_wr(input logic [6:0] a, input logic [7:0] d);
        logic [8:0] r;
        sda_lo = 0; scl = 1; hw; sda_lo = 1; hw; scl = 0; hw;
        xfer({a, 2'b01}, r); ack[1] = r[0];
        xfer({d, 1'b1}, r); ack[0] = r[0];
        sda_lo = 1; hw; scl = 1; hw; sda_lo = 0; hw;
    endtask
    task automatic i2c_rd;
        logic [8:0] r;
        sda_lo = 0; scl = 1; hw; sda_lo = 1; hw; scl = 0; hw;
        xfer({I2C_TARGET_ADDR, 2'b11}, r); ack[1] = r[0];
        xfer(9'h1FE, r); st = r[8:1];
        xfer(9'h1FF, r); tp = r[8:1];
        sda_lo = 1; hw; scl = 1; hw; sda_lo = 0; hw;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset_boot;
        repeat (7) @(negedge mclk);
        check("irq_oe", irq_oe, 0);
        check("lsel", lsel, 0);
        check("sel", {fsel_n, spare_n, sdaoe}, 3'b110);
        @(negedge mclk) rst_b = 1;
        repeat (2) @(negedge mclk);
        check("irq", {irq_oe, irq_out, fsel_n}, 3'b110);
        for (int i = 0; i < 2000 && irq_out !== 1'b0; i++) @(negedge mclk);
        check("irq_done", {irq_oe, irq_out, fsel_n}, 3'b101);
        check("lsel_idle", lsel, 0);
        check("hdr", hdr, {FLASH_READ_CMD, 24'h0});
    endtask
    task t_sequence;
        logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
        i2c_wr(I2C_TARGET_ADDR, 8'h01);
        check("ack_run", ack, 0);
        for (int i = 0; i < 100 && lsel === 2'h0; i++) @(negedge mclk);
        for (int k = 0; k < 5; k++) begin
            check("lsel_step", lsel, codes[k % 4]);
            repeat (STEP_CYC) @(negedge mclk);
        end
        i2c_wr(7'h1C, 8'h00);
        check("ack_foreign", ack, 2'b11);
        check("lsel_kept", lsel != 2'h0, 1);
        i2c_wr(I2C_TARGET_ADDR, 8'h00);
        repeat (2) @(negedge mclk);
        check("lsel_off", lsel, 0);
    endtask
    task t_convert;
        int seen = 0;
        i2c_wr(I2C_TARGET_ADDR, 8'h02);
        for (int i = 0; i < 400 && !seen; i++) begin
            @(negedge mclk);
            seen = (ramp === 1'b1);
        end
        check("ramp_on", seen, 1);
        repeat (12000) @(negedge mclk);
        i2c_rd;
        check("rd_ack", ack[1], 0);
        check("status", st, 8'h80);
        check("temp", tp, 8'h5A);
    endtask
    initial begin
        t_reset_boot;
        t_sequence;
        t_convert;
        stop_test;
    end
endmodule
